// file: hdl/temp_sensor_regs.sv
// Sensor end: register-select latch, setup, measured value and limit registers
// Function
// - Eight-bit select, low two bits, upper zero
// - Select 00 measured, 01 setup, 10/11 limits
// - Select loaded only from command byte
// - Select retained; reads may omit it
// - Controller always sends select on writes
// - Select is 00 after reset
// - Controller discards first temperature read
// - Setup top three bits RW, reset zero
// - Fault queue codes map to 1,2,4,6
// - Polarity 0 active low, 1 active high
// - Polarity at setup bit 2
// - Mode 0 comparator, 1 interrupt
// - Mode at setup bit 1
// - Power-down 0 normal, 1 power-down
// - Power-down at setup bit 0
// - Measured value 11-bit, read-only, per conversion
// - Result bits packed high, low five zero
// - Measured read gives 16 bits, high first
// - Single-byte measured read gives high byte
// - Limits are 9-bit two-byte RW registers
// - Limit bit 0 at low bit 7, rest zero
// - Compare against both limits per conversion
// - Compare uses nine top measured bits
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_regs (
  // Link to the bus controller
  sensor_link_if.device link,
  // Converter side
  input  wire logic        convDone,
  input  wire logic [10:0] convData,
  // Setup outputs
  output logic [2:0]       faultCount,
  output logic [1:0]       fault_queue_field,
  output logic             alarm_polarity,
  output logic             alarm_mode_select,
  output logic             powerDown,
  // Comparison results
  output logic             cmpValid,
  output logic             aboveUpper,
  output logic             belowLower,
  // Register read notice
  output logic             regRead
);

  logic [7:0]  select_r;
  logic [7:0]  setup_r;
  logic [10:0] measured_r;
  logic [8:0]  upper_r;
  logic [8:0]  lower_r;
  logic        expectSel_r;
  logic        inWrite_r;
  logic        byteIdx_r;
  logic        devAck_r;
  logic [7:0]  devRdata_r;
  logic        cmpValid_r;
  logic        aboveUpper_r;
  logic        belowLower_r;
  logic        regRead_r;
  logic [1:0]  selCode;
  logic        byteOp;
  logic        wrByte;
  logic        rdByte;
  logic [15:0] readWord;
  logic [7:0]  readByte;
  logic [8:0]  tempNine;
  logic        upAbove;
  logic        lowBelow;

  assign selCode = select_r[1:0];
  assign byteOp  = link.linkValid && (link.linkOp == temp_sensor_pkg::OP_BYTE);
  assign wrByte  = byteOp && inWrite_r && !expectSel_r;
  assign rdByte  = byteOp && !inWrite_r;

  // Every link operation is answered one cycle later
  always_ff @(posedge link.clk_sys) begin
    if (link.reset) begin
      devAck_r <= 1'b0;
    end else begin
      devAck_r <= link.linkValid;
    end
  end

  // Transaction phase tracking
  always_ff @(posedge link.clk_sys) begin
    if (link.reset) begin
      expectSel_r <= 1'b0;
      inWrite_r   <= 1'b0;
      byteIdx_r   <= 1'b0;
    end else if (link.linkValid) begin
      unique case (link.linkOp)
        temp_sensor_pkg::OP_START_WR: begin
          expectSel_r <= 1'b1;
          inWrite_r   <= 1'b1;
          byteIdx_r   <= 1'b0;
        end
        temp_sensor_pkg::OP_START_RD: begin
          expectSel_r <= 1'b0;
          inWrite_r   <= 1'b0;
          byteIdx_r   <= 1'b0;
        end
        temp_sensor_pkg::OP_BYTE: begin
          if (inWrite_r && expectSel_r) begin
            expectSel_r <= 1'b0;
          end else begin
            byteIdx_r <= 1'b1;
          end
        end
        temp_sensor_pkg::OP_STOP: begin
          expectSel_r <= 1'b0;
          inWrite_r   <= 1'b0;
          byteIdx_r   <= 1'b0;
        end
      endcase
    end
  end

  // Select latch: first byte of a write command, upper six bits forced to zero
  always_ff @(posedge link.clk_sys) begin
    if (link.reset) begin
      select_r <= temp_sensor_pkg::SELECT_RESET;
    end else if (byteOp && inWrite_r && expectSel_r) begin
      select_r <= {6'h00, link.linkWdata[1:0]};
    end
  end

  // Setup byte, all eight bits writable
  always_ff @(posedge link.clk_sys) begin
    if (link.reset) begin
      setup_r <= temp_sensor_pkg::SETUP_RESET;
    end else if (wrByte && !byteIdx_r && selCode == temp_sensor_pkg::SEL_SETUP) begin
      setup_r <= link.linkWdata;
    end
  end

  // Limit registers: high byte carries bits 8..1, low byte bit 7 carries bit 0
  always_ff @(posedge link.clk_sys) begin
    if (link.reset) begin
      upper_r <= temp_sensor_pkg::UPPER_RESET;
      lower_r <= temp_sensor_pkg::LOWER_RESET;
    end else if (wrByte) begin
      if (selCode == temp_sensor_pkg::SEL_UPPER) begin
        if (!byteIdx_r) begin
          upper_r[8:1] <= link.linkWdata;
        end else begin
          upper_r[0] <= link.linkWdata[7];
        end
      end
      if (selCode == temp_sensor_pkg::SEL_LOWER) begin
        if (!byteIdx_r) begin
          lower_r[8:1] <= link.linkWdata;
        end else begin
          lower_r[0] <= link.linkWdata[7];
        end
      end
    end
  end

  // Measured value only changes at the end of a conversion, never from the link
  always_ff @(posedge link.clk_sys) begin
    if (link.reset) begin
      measured_r <= temp_sensor_pkg::TEMP_RESET;
    end else if (convDone) begin
      measured_r <= convData;
    end
  end

  // Read word per selection
  always_comb begin
    unique case (selCode)
      temp_sensor_pkg::SEL_MEASURED: readWord = {measured_r, 5'h00};
      temp_sensor_pkg::SEL_SETUP:    readWord = {setup_r, setup_r};
      temp_sensor_pkg::SEL_LOWER:    readWord = {lower_r, 7'h00};
      temp_sensor_pkg::SEL_UPPER:    readWord = {upper_r, 7'h00};
    endcase
  end

  // High byte first; a one-byte read simply stops after it
  assign readByte = byteIdx_r ? readWord[7:0] : readWord[15:8];

  always_ff @(posedge link.clk_sys) begin
    if (link.reset) begin
      devRdata_r <= 8'h00;
      regRead_r  <= 1'b0;
    end else begin
      regRead_r <= rdByte;
      if (rdByte) begin
        devRdata_r <= readByte;
      end
    end
  end

  // Limit comparison on the nine top bits of the new result
  assign tempNine = convData[10:2];

  limit_compare upperCmp (
    .tempNine  (tempNine),
    .limitNine (upper_r),
    .isAbove   (upAbove),
    .isBelow   ()
  );

  limit_compare lowerCmp (
    .tempNine  (tempNine),
    .limitNine (lower_r),
    .isAbove   (),
    .isBelow   (lowBelow)
  );

  always_ff @(posedge link.clk_sys) begin
    if (link.reset) begin
      cmpValid_r   <= 1'b0;
      aboveUpper_r <= 1'b0;
      belowLower_r <= 1'b0;
    end else begin
      cmpValid_r <= convDone;
      if (convDone) begin
        aboveUpper_r <= upAbove;
        belowLower_r <= lowBelow;
      end
    end
  end

  // Fault queue decode
  always_comb begin
    unique case (setup_r[temp_sensor_pkg::FAULT_QUEUE_MSB:temp_sensor_pkg::FAULT_QUEUE_LSB])
      2'h0: faultCount = temp_sensor_pkg::FAULTS_CODE0;
      2'h1: faultCount = temp_sensor_pkg::FAULTS_CODE1;
      2'h2: faultCount = temp_sensor_pkg::FAULTS_CODE2;
      2'h3: faultCount = temp_sensor_pkg::FAULTS_CODE3;
    endcase
  end

  assign fault_queue_field =
    setup_r[temp_sensor_pkg::FAULT_QUEUE_MSB:temp_sensor_pkg::FAULT_QUEUE_LSB];
  assign alarm_polarity    = setup_r[temp_sensor_pkg::ALARM_POL_BIT];
  assign alarm_mode_select = setup_r[temp_sensor_pkg::ALARM_MODE_BIT];
  assign powerDown         = setup_r[temp_sensor_pkg::POWER_DOWN_BIT];

  assign cmpValid      = cmpValid_r;
  assign aboveUpper    = aboveUpper_r;
  assign belowLower    = belowLower_r;
  assign regRead       = regRead_r;
  assign link.devAck   = devAck_r;
  assign link.devRdata = devRdata_r;

endmodule : temp_sensor_regs
`default_nettype wire

// file: hdl/temp_sensor_pkg.sv
// Shared constants and types for the temperature sensor register file and its controller
package temp_sensor_pkg;

  // Register selection codes
  typedef enum logic [1:0] {
    SEL_MEASURED = 2'h0,
    SEL_SETUP    = 2'h1,
    SEL_LOWER    = 2'h2,
    SEL_UPPER    = 2'h3
  } sel_t;

  // Link operations issued by the controller
  typedef enum logic [1:0] {
    OP_START_WR = 2'h0,
    OP_START_RD = 2'h1,
    OP_BYTE     = 2'h2,
    OP_STOP     = 2'h3
  } op_t;

  // Setup byte field positions
  localparam int SETUP_RSVD_MSB   = 7;
  localparam int SETUP_RSVD_LSB   = 5;
  localparam int FAULT_QUEUE_MSB  = 4;
  localparam int FAULT_QUEUE_LSB  = 3;
  localparam int ALARM_POL_BIT    = 2;
  localparam int ALARM_MODE_BIT   = 1;
  localparam int POWER_DOWN_BIT   = 0;

  // Values after reset
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] SETUP_RESET  = 8'h00;
  localparam logic [8:0] UPPER_RESET  = 9'h0A0;
  localparam logic [8:0] LOWER_RESET  = 9'h096;
  localparam logic [10:0] TEMP_RESET  = 11'h000;

  // Fault queue counts for codes 00..11
  localparam logic [2:0] FAULTS_CODE0 = 3'h1;
  localparam logic [2:0] FAULTS_CODE1 = 3'h2;
  localparam logic [2:0] FAULTS_CODE2 = 3'h4;
  localparam logic [2:0] FAULTS_CODE3 = 3'h6;

  // Controller register offsets on APB
  localparam logic [7:0] ADDR_SELECT = 8'h00;
  localparam logic [7:0] ADDR_WDATA  = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_RDATA  = 8'h10;

  // Command register bits
  localparam int CMD_WRITE_BIT    = 0;
  localparam int CMD_ONE_BYTE_BIT = 1;

  // Status register bits
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_DISCARDED_BIT = 1;
  localparam int STAT_FIRST_DONE    = 2;

endpackage : temp_sensor_pkg

// file: hdl/sensor_link_if.sv
// Byte-level link between the bus controller and the sensor register file
`timescale 1ns/1ps
`default_nettype none
interface sensor_link_if (
  input wire logic clk_sys,
  input wire logic reset
);
  logic                  linkValid;
  temp_sensor_pkg::op_t  linkOp;
  logic [7:0]            linkWdata;
  logic                  devAck;
  logic [7:0]            devRdata;

  modport device (
    input  clk_sys, reset, linkValid, linkOp, linkWdata,
    output devAck, devRdata
  );
  modport host (
    input  clk_sys, reset, devAck, devRdata,
    output linkValid, linkOp, linkWdata
  );
endinterface : sensor_link_if
`default_nettype wire

// file: hdl/limit_compare.sv
// Signed comparison of a 9-bit temperature against one limit
`timescale 1ns/1ps
`default_nettype none
module limit_compare (
  // Operands
  input  wire logic [8:0] tempNine,
  input  wire logic [8:0] limitNine,
  // Results
  output logic            isAbove,
  output logic            isBelow
);
  assign isAbove = $signed(tempNine) > $signed(limitNine);
  assign isBelow = $signed(tempNine) < $signed(limitNine);
endmodule : limit_compare
`default_nettype wire

// file: hdl/sensor_bus_ctrl.sv
// Controller end: APB command registers driving sensor register transactions
`timescale 1ns/1ps
`default_nettype none
module sensor_bus_ctrl (
  // Link to the sensor
  sensor_link_if.host link,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  typedef enum logic [2:0] {
    H_IDLE     = 3'h0,
    H_START_WR = 3'h1,
    H_SEL      = 3'h2,
    H_WDATA    = 3'h3,
    H_START_RD = 3'h4,
    H_RDATA    = 3'h5,
    H_STOP     = 3'h6
  } hstate_t;

  hstate_t     state_r;
  logic [1:0]  sel_r;
  logic [1:0]  lastSel_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic        isWrite_r;
  logic        twoBytes_r;
  logic        byteIdx_r;
  logic        waitAck_r;
  logic        firstDone_r;
  logic        discarded_r;
  logic        linkValid_r;
  temp_sensor_pkg::op_t linkOp_r;
  logic [7:0]  linkWdata_r;
  logic        apbWr;
  logic        mapped;
  logic        cmdGo;
  logic        lastByte;
  logic        discard;

  assign apbWr   = psel && penable && pwrite;
  assign mapped  = paddr == temp_sensor_pkg::ADDR_SELECT || paddr == temp_sensor_pkg::ADDR_WDATA
                || paddr == temp_sensor_pkg::ADDR_CMD || paddr == temp_sensor_pkg::ADDR_STATUS
                || paddr == temp_sensor_pkg::ADDR_RDATA;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign cmdGo   = apbWr && paddr == temp_sensor_pkg::ADDR_CMD && state_r == H_IDLE;
  assign lastByte = !twoBytes_r || byteIdx_r;
  assign discard  = sel_r == temp_sensor_pkg::SEL_MEASURED && !firstDone_r;

  always_comb begin
    unique case (paddr)
      temp_sensor_pkg::ADDR_SELECT: prdata = {30'h0, sel_r};
      temp_sensor_pkg::ADDR_WDATA:  prdata = {16'h0, wdata_r};
      temp_sensor_pkg::ADDR_STATUS: prdata = {29'h0, firstDone_r, discarded_r,
                                              state_r != H_IDLE};
      temp_sensor_pkg::ADDR_RDATA:  prdata = {16'h0, rdata_r};
      default:                      prdata = 32'h0;
    endcase
  end

  // Software-written registers
  always_ff @(posedge link.clk_sys) begin
    if (link.reset) begin
      sel_r   <= 2'h0;
      wdata_r <= 16'h0000;
    end else if (apbWr && state_r == H_IDLE) begin
      if (paddr == temp_sensor_pkg::ADDR_SELECT) begin
        sel_r <= pwdata[1:0];
      end
      if (paddr == temp_sensor_pkg::ADDR_WDATA) begin
        wdata_r <= pwdata[15:0];
      end
    end
  end

  // Transaction sequencer
  always_ff @(posedge link.clk_sys) begin
    if (link.reset) begin
      state_r     <= H_IDLE;
      lastSel_r   <= temp_sensor_pkg::SEL_MEASURED;
      isWrite_r   <= 1'b0;
      twoBytes_r  <= 1'b0;
      byteIdx_r   <= 1'b0;
      waitAck_r   <= 1'b0;
      linkValid_r <= 1'b0;
      linkOp_r    <= temp_sensor_pkg::OP_STOP;
      linkWdata_r <= 8'h00;
      rdata_r     <= 16'h0000;
      firstDone_r <= 1'b0;
      discarded_r <= 1'b0;
    end else begin
      linkValid_r <= 1'b0;
      if (cmdGo) begin
        isWrite_r  <= pwdata[temp_sensor_pkg::CMD_WRITE_BIT];
        twoBytes_r <= sel_r != temp_sensor_pkg::SEL_SETUP
                      && !(pwdata[temp_sensor_pkg::CMD_ONE_BYTE_BIT]
                           && sel_r == temp_sensor_pkg::SEL_MEASURED
                           && !pwdata[temp_sensor_pkg::CMD_WRITE_BIT]);
        byteIdx_r  <= 1'b0;
        if (pwdata[temp_sensor_pkg::CMD_WRITE_BIT] || sel_r != lastSel_r) begin
          state_r <= H_START_WR;
        end else begin
          state_r <= H_START_RD;
        end
      end else if (state_r != H_IDLE && !waitAck_r) begin
        linkValid_r <= 1'b1;
        waitAck_r   <= 1'b1;
        unique case (state_r)
          H_START_WR: linkOp_r <= temp_sensor_pkg::OP_START_WR;
          H_START_RD: linkOp_r <= temp_sensor_pkg::OP_START_RD;
          H_STOP:     linkOp_r <= temp_sensor_pkg::OP_STOP;
          default:    linkOp_r <= temp_sensor_pkg::OP_BYTE;
        endcase
        if (state_r == H_SEL) begin
          linkWdata_r <= {6'h00, sel_r};
        end else begin
          linkWdata_r <= byteIdx_r ? wdata_r[7:0] : wdata_r[15:8];
        end
      end else if (waitAck_r && link.devAck) begin
        waitAck_r <= 1'b0;
        unique case (state_r)
          H_START_WR: state_r <= H_SEL;
          H_SEL: begin
            lastSel_r <= sel_r;
            state_r   <= isWrite_r ? H_WDATA : H_START_RD;
          end
          H_WDATA: begin
            byteIdx_r <= 1'b1;
            state_r   <= lastByte ? H_STOP : H_WDATA;
          end
          H_START_RD: state_r <= H_RDATA;
          H_RDATA: begin
            byteIdx_r <= 1'b1;
            if (!discard) begin
              if (byteIdx_r) begin
                rdata_r[7:0] <= link.devRdata;
              end else begin
                rdata_r <= {link.devRdata, 8'h00};
              end
            end
            if (lastByte) begin
              state_r <= H_STOP;
              if (sel_r == temp_sensor_pkg::SEL_MEASURED) begin
                firstDone_r <= 1'b1;
                discarded_r <= discard;
              end
            end else begin
              state_r <= H_RDATA;
            end
          end
          H_STOP:  state_r <= H_IDLE;
          default: state_r <= H_IDLE;
        endcase
      end
    end
  end

  assign link.linkValid = linkValid_r;
  assign link.linkOp    = linkOp_r;
  assign link.linkWdata = linkWdata_r;

endmodule : sensor_bus_ctrl
`default_nettype wire

// file: testbench/sensor_link_sva.sv
// Link protocol assertions between the controller end and the sensor end
`timescale 1ns/1ps
`default_nettype none
module sensor_link_sva (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                reset,
  // Link signals
  input wire logic                linkValid,
  input var temp_sensor_pkg::op_t linkOp,
  input wire logic [7:0]          linkWdata,
  input wire logic                devAck,
  input wire logic [7:0]          devRdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_wr;
    linkValid && linkOp == temp_sensor_pkg::OP_START_WR;
  endsequence
  sequence s_rd;
    linkValid && linkOp == temp_sensor_pkg::OP_START_RD;
  endsequence
  sequence s_byte;
    linkValid && linkOp == temp_sensor_pkg::OP_BYTE;
  endsequence

  ack_follows_valid_a: assert property (linkValid |=> devAck)
    else $error("devAck missing one cycle after linkValid");
  ack_has_cause_a: assert property (devAck |-> $past(linkValid))
    else $error("devAck without a preceding linkValid");
  valid_spacing_a: assert property (linkValid |=> !linkValid)
    else $error("linkValid on two cycles in a row");
  write_has_select_a: assert property (s_wr |-> ##3 s_byte)
    else $error("write start not followed by a select byte");
  select_top_zero_a: assert property (s_wr ##3 s_byte |-> linkWdata[7:2] == 6'h00)
    else $error("select byte has upper bits set");
  read_has_byte_a: assert property (s_rd |-> ##3 s_byte)
    else $error("read start not followed by a byte");
  rdata_hold_a: assert property (!devAck |-> $stable(devRdata))
    else $error("devRdata changed without devAck");
  txn_ends_stop_a: assert property (s_wr |-> ##[9:15] (linkValid && linkOp == temp_sensor_pkg::OP_STOP))
    else $error("transaction not closed by a stop");
endmodule : sensor_link_sva
`default_nettype wire

// file: testbench/temp_sensor_register_file_tb.sv
// Self-checking bench for the sensor register file and its APB controller
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_register_file_tb;
  logic        clk_sys, reset, convDone, psel, penable, pwrite, pready, pslverr, err;
  logic        cmpValid, aboveUpper, belowLower, polarity, modeSel, powerDown, regRead;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [10:0] convData;
  logic [2:0]  faultCount;
  logic [1:0]  faultField;
  int          mismatches, nTests;
  int          cycles = 0;
  int          nReads = 0;
  logic [2:0]  fq [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  logic [10:0] cv [5] = '{11'h0C8, 11'h0CC, 11'h0CB, 11'h734, 11'h738};

  sensor_link_if sensor_link_if_i (.clk_sys(clk_sys), .reset(reset));
  temp_sensor_regs temp_sensor_regs_i (.link(sensor_link_if_i), .convDone(convDone),
    .convData(convData), .faultCount(faultCount), .fault_queue_field(faultField),
    .alarm_polarity(polarity), .alarm_mode_select(modeSel), .powerDown(powerDown),
    .cmpValid(cmpValid), .aboveUpper(aboveUpper), .belowLower(belowLower), .regRead(regRead));
  sensor_bus_ctrl sensor_bus_ctrl_i (.link(sensor_link_if_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  sensor_link_sva sensor_link_sva_i (.clk_sys(clk_sys), .reset(reset),
    .linkValid(sensor_link_if_i.linkValid), .linkOp(sensor_link_if_i.linkOp),
    .linkWdata(sensor_link_if_i.linkWdata), .devAck(sensor_link_if_i.devAck),
    .devRdata(sensor_link_if_i.devRdata));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Count read bytes served by the sensor end
  always @(posedge clk_sys) begin
    if (regRead === 1'b1) begin
      nReads <= nReads + 1;
    end
  end

  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      wrap_up();
    end
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wrap_up();
    if (mismatches == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One sensor transaction, then fetch the read-back word
  task dev_op(input logic [1:0] sel, input logic [31:0] cmd, input logic [15:0] d);
    apb(1'b1, temp_sensor_pkg::ADDR_SELECT, {30'h0, sel});
    apb(1'b1, temp_sensor_pkg::ADDR_WDATA, {16'h0, d});
    apb(1'b1, temp_sensor_pkg::ADDR_CMD, cmd);
    do apb(1'b0, temp_sensor_pkg::ADDR_STATUS, 32'h0); while (q[0] !== 1'b0);
    apb(1'b0, temp_sensor_pkg::ADDR_RDATA, 32'h0);
  endtask : dev_op

  task conv(input logic [10:0] d);
    @(posedge clk_sys);
    convDone <= 1'b1;
    convData <= d;
    @(posedge clk_sys);
    convDone <= 1'b0;
    @(posedge clk_sys);
    check("cmpValid", cmpValid, 1'b1);
  endtask : conv

  task t_reset();
    check("faultCount", faultCount, 3'h1);
    check("setup outputs", {faultField, polarity, modeSel, powerDown}, 5'h00);
    conv(11'h0C8);
    dev_op(2'h0, 32'h0, 16'h0);
    apb(1'b0, temp_sensor_pkg::ADDR_STATUS, 32'h0);
    check("first read status", q[2:1], 2'h3);
    dev_op(2'h0, 32'h0, 16'h0);
    check("measured default select", q[15:0], 16'h1900);
    apb(1'b0, temp_sensor_pkg::ADDR_STATUS, 32'h0);
    check("second read status", q[2:1], 2'h2);
    dev_op(2'h1, 32'h0, 16'h0);
    check("setup reset", q[15:8], 8'h00);
    dev_op(2'h3, 32'h0, 16'h0);
    check("upper reset", q[15:0], 16'h5000);
    dev_op(2'h2, 32'h0, 16'h0);
    check("lower reset", q[15:0], 16'h4B00);
  endtask : t_reset

  task t_setup();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {(i == 3) ? 3'h7 : 3'h0, i[1:0], i[0], ~i[0], i[1]};
      dev_op(2'h1, 32'h1, {v, 8'h00});
      check("faultCount", faultCount, fq[i]);
      check("queue field", faultField, i[1:0]);
      check("polarity", polarity, v[2]);
      check("mode", modeSel, v[1]);
      check("power down", powerDown, v[0]);
      dev_op(2'h1, 32'h0, 16'h0);
      check("setup read", q[15:8], v);
    end
    dev_op(2'h1, 32'h1, 16'h0);
  endtask : t_setup

  task t_limits();
    dev_op(2'h3, 32'h1, 16'h7FFF);
    dev_op(2'h3, 32'h0, 16'h0);
    check("upper", q[15:0], 16'h7F80);
    dev_op(2'h3, 32'h0, 16'h0);
    check("upper again", q[15:0], 16'h7F80);
    dev_op(2'h2, 32'h1, 16'h80FF);
    dev_op(2'h2, 32'h0, 16'h0);
    check("lower", q[15:0], 16'h8080);
  endtask : t_limits

  task t_measured();
    int n0;
    conv(11'h649);
    n0 = nReads;
    dev_op(2'h0, 32'h0, 16'h0);
    check("measured", q[15:0], 16'hC920);
    check("regRead two bytes", nReads - n0, 32'h2);
    n0 = nReads;
    dev_op(2'h0, 32'h2, 16'h0);
    check("measured one byte", q[15:0], 16'hC900);
    check("regRead one byte", nReads - n0, 32'h1);
    dev_op(2'h0, 32'h1, 16'h1234);
    dev_op(2'h0, 32'h0, 16'h0);
    check("measured after write", q[15:0], 16'hC920);
  endtask : t_measured

  task t_compare();
    dev_op(2'h3, 32'h1, 16'h1900);
    dev_op(2'h2, 32'h1, 16'hE700);
    for (int i = 0; i < 5; i++) begin
      conv(cv[i]);
      check("aboveUpper", aboveUpper, (i == 1));
      check("belowLower", belowLower, (i == 3));
    end
  endtask : t_compare

  task t_bad_addr();
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped read err", err, 1'b1);
    check("unmapped read data", q, 32'h0);
    apb(1'b1, 8'h24, 32'hFFFF);
    check("unmapped write err", err, 1'b1);
  endtask : t_bad_addr

  initial begin
    reset = 1'b1;
    convDone = 1'b0;
    convData = 11'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    nTests = 0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_setup();
    t_limits();
    t_measured();
    t_compare();
    t_bad_addr();
    wrap_up();
  end
endmodule : temp_sensor_register_file_tb
`default_nettype wire
